// *** acr_pkg.sv ***
package acr_pkg;

  // ==========================================================================
  // register map: printed offsets are word indices, byte address is four times
  // ==========================================================================
  localparam int unsigned AXI_ADDR_W = 8;
  localparam logic [AXI_ADDR_W-1:0] CFG_CTRL_IDX = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] ADDR_CFG_IDX = 8'h06;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================================
  // configuration control fields
  // ==========================================================================
  localparam int unsigned STRAP_LSB = 8;
  localparam int unsigned BUS_TYPE_BIT = 14;
  localparam int unsigned AUI_BIT = 13;
  localparam int unsigned COAX_BIT = 12;
  localparam int unsigned MODE_LSB = 10;
  localparam int unsigned TP_BIT = 9;
  localparam int unsigned CLK_SEL_BIT = 8;
  localparam int unsigned RESET_BIT = 2;
  localparam int unsigned ENABLE_BIT = 0;
  localparam logic [1:0] MODE_NORMAL = 2'b11;

  // ==========================================================================
  // address configuration fields
  // ==========================================================================
  localparam int unsigned TRANSCEIVER_SELECT_LSB = 14;
  localparam int unsigned ROM_SIZE_LSB = 12;
  localparam int unsigned ROM_BASE_LSB = 8;
  localparam int unsigned SW_INFO_BIT = 7;
  localparam int unsigned IO_BASE_LSB = 0;
  localparam logic [15:0] ADDR_CFG_RESET = 16'h0000;
  localparam logic [1:0] TRANSCEIVER_SELECT_TP = 2'b00;
  localparam logic [1:0] TRANSCEIVER_SELECT_AUI = 2'b01;
  localparam logic [1:0] TRANSCEIVER_SELECT_COAX = 2'b11;
  localparam logic [1:0] ROM_SIZE_8K = 2'b00;
  localparam logic [5:0] EE_ADDR_CFG_WORD = 6'h08;
  localparam logic [5:0] IO_FIXED_MID = 6'h20;
  localparam logic [6:0] ROM_8K_FIRST = 7'h60;
  localparam logic [5:0] ROM_16K_FIRST = 6'h30;
  localparam logic [1:0] STRAP_FILL_FULL = 2'h3;

  typedef enum logic [1:0] {
    LAYOUT_ORIGINAL = 2'h0,
    LAYOUT_LATER = 2'h1,
    LAYOUT_CHANNEL = 2'h2
  } acr_layout_t;

  typedef enum logic [2:0] {
    PH_STRAP = 3'b001,
    PH_LOAD = 3'b010,
    PH_RUN = 3'b100
  } acr_phase_t;

  typedef struct packed {
    logic awvalid;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_ADDR_W-1:0] araddr;
    logic rready;
  } acr_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } acr_axi_rsp_t;

endpackage

// *** acr_adapter_config_registers.sv ***
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
// Summary of operation
// - strap option bits are read-only
// - later layout bit 14: 0 card, 1 ISA
// - bit 13 reports external transceiver connector
// - bit 12 reports on-board coax transceiver
// - mode strap 11 alone means normal operation
// - bit 9 reports on-board twisted-pair transceiver
// - original/channel bit 8: encoder/decoder select
// - later layout bit 8: oscillator select
// - writing reset bit restores power-on state
// - enable low kills irq drivers, EISA rom decode
// - enable set by driver/firmware, ignored on card
// - channel layout same option bits, no bus bit
// - channel reset hides adapter until reconfigured
// - address config auto-loads from EEPROM word 0x08, except on a later layout card
// - address config bit 7 is plain storage
// - select 00 enables twisted-pair transceiver
// - select 01 external port, 10 undefined
// - select 11 enables coax transceiver
// - io window compares base with A15..A10
// - large roms still use 16K window
module acr_adapter_config_registers #(
  parameter acr_pkg::acr_layout_t LAYOUT = acr_pkg::LAYOUT_LATER,
  parameter bit AUTO_LOAD = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire acr_pkg::acr_axi_req_t axi_req,
  output acr_pkg::acr_axi_rsp_t axi_rsp,
  input wire logic [7:0] strap_pins,
  input wire logic [15:0] host_io_addr,
  input wire logic [19:0] host_mem_addr,
  input wire logic slot_configured,
  output logic ee_req,
  output logic [5:0] ee_addr,
  input wire logic ee_ack,
  input wire logic [15:0] ee_data,
  output logic adapter_reset,
  output logic slot_visible,
  output logic irq_drive_en,
  output logic io_hit,
  output logic rom_hit,
  output logic transceiver_select_tp_en,
  output logic transceiver_select_aui_en,
  output logic transceiver_select_coax_en,
  output logic internal_clk_sel,
  output logic mode_normal
);
  import acr_pkg::*;

  // ==========================================================================
  // state
  // ==========================================================================
  // strap vector: [7] EISA mode pin, [6:0] option bits 14..8
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [1:0] fill;
    logic [7:0] strap;
    acr_phase_t phase;
    logic enable;
    logic [15:0] addr_cfg;
    logic ee_req;
    logic slot_visible;
    logic adapter_reset;
    logic irq_drive_en;
    logic io_hit;
    logic rom_hit;
    logic transceiver_select_tp_en;
    logic transceiver_select_aui_en;
    logic transceiver_select_coax_en;
    logic internal_clk_sel;
    logic mode_normal;
    logic aw_got;
    logic w_got;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    acr_axi_rsp_t rsp;
  } acr_state_t;

  localparam bit CHANNEL = (LAYOUT == LAYOUT_CHANNEL);
  localparam logic [AXI_ADDR_W-1:0] CFG_CTRL_ADDR = AXI_ADDR_W'(CFG_CTRL_IDX * 4);
  localparam logic [AXI_ADDR_W-1:0] ADDR_CFG_ADDR = AXI_ADDR_W'(ADDR_CFG_IDX * 4);

  acr_state_t state_reg;
  acr_state_t state_next;

  // power-on values of everything except the bus handshake
  function automatic acr_state_t core_reset(input acr_state_t s);
    acr_state_t r;
    r = s;
    r.s1 = 8'h00;
    r.s2 = 8'h00;
    r.s3 = 8'h00;
    r.fill = 2'h0;
    r.strap = 8'h00;
    r.phase = PH_STRAP;
    r.enable = 1'b0;
    r.addr_cfg = ADDR_CFG_RESET;
    r.ee_req = 1'b0;
    r.slot_visible = !CHANNEL;
    r.adapter_reset = 1'b0;
    r.irq_drive_en = 1'b0;
    r.io_hit = 1'b0;
    r.rom_hit = 1'b0;
    r.transceiver_select_tp_en = 1'b0;
    r.transceiver_select_aui_en = 1'b0;
    r.transceiver_select_coax_en = 1'b0;
    r.internal_clk_sel = 1'b0;
    r.mode_normal = 1'b0;
    return r;
  endfunction

  function automatic acr_state_t full_reset();
    acr_state_t r;
    r = '0;
    r = core_reset(r);
    r.rsp.awready = 1'b1;
    r.rsp.wready = 1'b1;
    r.rsp.arready = 1'b1;
    return r;
  endfunction

  // ==========================================================================
  // register read view
  // ==========================================================================
  function automatic logic [15:0] cfg_view(input acr_state_t s);
    logic [15:0] v;
    v = 16'h0000;
    unique case (LAYOUT)
      LAYOUT_LATER: begin
        v = {1'b1, s.strap[6:0], 7'h00, s.enable};
      end
      LAYOUT_CHANNEL: begin
        v = {2'b00, s.strap[5:0], 7'h00, 1'b1};
      end
      default: begin
        v = {2'b00, s.strap[5:0], 7'h00, s.enable};
      end
    endcase
    return v;
  endfunction

  function automatic logic [31:0] read_word(input acr_state_t s, input logic [AXI_ADDR_W-1:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == CFG_CTRL_ADDR) begin
      d = {16'h0000, cfg_view(s)};
    end else if (a == ADDR_CFG_ADDR) begin
      d = {16'h0000, s.addr_cfg};
    end
    return d;
  endfunction

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    logic pc_card;
    logic eff_enable;
    logic eisa;
    logic rom_ok;
    logic soft_reset;
    logic [1:0] xsel;
    logic [1:0] rom_size;
    logic [3:0] rom_base;
    logic [5:0] io_sel;
    logic [7:0] cap;
    state_next = state_reg;
    soft_reset = 1'b0;
    state_next.adapter_reset = 1'b0;

    // three-stage pin sampler; a level counts once stages two and three agree
    state_next.s1 = strap_pins;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    if (state_reg.fill != STRAP_FILL_FULL) begin
      state_next.fill = state_reg.fill + 2'h1;
    end
    cap = state_reg.s3;

    // straps are latched after each power-on or soft reset and never written by the host
    if (state_reg.phase == PH_STRAP) begin
      if (state_reg.fill == STRAP_FILL_FULL && state_reg.s2 == state_reg.s3) begin
        state_next.strap = cap;
        if (AUTO_LOAD && !(LAYOUT == LAYOUT_LATER && !cap[BUS_TYPE_BIT-STRAP_LSB])) begin
          state_next.phase = PH_LOAD;
          state_next.ee_req = 1'b1;
        end else begin
          state_next.phase = PH_RUN;
        end
      end
    end else if (state_reg.phase == PH_LOAD) begin
      if (ee_ack) begin
        state_next.addr_cfg = ee_data;
        state_next.ee_req = 1'b0;
        state_next.phase = PH_RUN;
      end
    end

    // ---------------- write channel ----------------
    if (state_reg.rsp.bvalid && axi_req.bready) begin
      state_next.rsp.bvalid = 1'b0;
    end
    if (axi_req.awvalid && state_reg.rsp.awready) begin
      state_next.aw_got = 1'b1;
      state_next.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && state_reg.rsp.wready) begin
      state_next.w_got = 1'b1;
      state_next.wdata = axi_req.wdata;
      state_next.wstrb = axi_req.wstrb;
    end
    if (state_next.aw_got && state_next.w_got && !state_reg.rsp.bvalid) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.rsp.bvalid = 1'b1;
      state_next.rsp.bresp = RESP_OKAY;
      if (state_next.awaddr == CFG_CTRL_ADDR) begin
        if (state_next.wstrb[0]) begin
          if (!CHANNEL) begin
            state_next.enable = state_next.wdata[ENABLE_BIT];
          end
          soft_reset = state_next.wdata[RESET_BIT];
        end
      end else if (state_next.awaddr == ADDR_CFG_ADDR) begin
        if (state_next.wstrb[0]) begin
          state_next.addr_cfg[7:0] = state_next.wdata[7:0];
        end
        if (state_next.wstrb[1]) begin
          state_next.addr_cfg[15:8] = state_next.wdata[15:8];
        end
      end else begin
        state_next.rsp.bresp = RESP_SLVERR;
      end
    end

    // ---------------- read channel ----------------
    if (state_reg.rsp.rvalid && axi_req.rready) begin
      state_next.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && state_reg.rsp.arready) begin
      state_next.rsp.rvalid = 1'b1;
      state_next.rsp.rdata = read_word(state_reg, axi_req.araddr);
      if (axi_req.araddr == CFG_CTRL_ADDR || axi_req.araddr == ADDR_CFG_ADDR) begin
        state_next.rsp.rresp = RESP_OKAY;
      end else begin
        state_next.rsp.rresp = RESP_SLVERR;
      end
    end

    // soft reset clears the adapter but lets the bus answer complete
    if (soft_reset) begin
      state_next = core_reset(state_next);
      state_next.adapter_reset = 1'b1;
    end

    if (slot_configured && CHANNEL) begin
      state_next.slot_visible = 1'b1;
    end

    state_next.rsp.awready = !state_next.aw_got && !state_next.rsp.bvalid;
    state_next.rsp.wready = !state_next.w_got && !state_next.rsp.bvalid;
    state_next.rsp.arready = !state_next.rsp.rvalid;

    // ---------------- derived outputs ----------------
    pc_card = (LAYOUT == LAYOUT_LATER) && !state_next.strap[BUS_TYPE_BIT-STRAP_LSB];
    eisa = state_next.strap[7];
    eff_enable = CHANNEL || pc_card || state_next.enable;
    xsel = state_next.addr_cfg[TRANSCEIVER_SELECT_LSB +: 2];
    rom_size = state_next.addr_cfg[ROM_SIZE_LSB +: 2];
    rom_base = state_next.addr_cfg[ROM_BASE_LSB +: 4];
    io_sel = {2'b00, state_next.addr_cfg[IO_BASE_LSB +: 4]};
    rom_ok = (state_next.phase == PH_RUN) && (rom_base != 4'h0) && !(eisa && !eff_enable);

    state_next.irq_drive_en = (state_next.phase == PH_RUN) && eff_enable;
    state_next.io_hit = (state_next.phase == PH_RUN)
                        && (host_io_addr[15:10] == io_sel)
                        && (host_io_addr[9:4] == IO_FIXED_MID);
    if (rom_size == ROM_SIZE_8K) begin
      state_next.rom_hit = rom_ok && (host_mem_addr[19:13] == ROM_8K_FIRST + {3'h0, rom_base});
    end else begin
      // every larger rom is seen through one 16K window
      state_next.rom_hit = rom_ok
                           && (host_mem_addr[19:14] == ROM_16K_FIRST + {3'h0, rom_base[3:1]});
    end
    state_next.transceiver_select_tp_en = (state_next.phase == PH_RUN) && (xsel == TRANSCEIVER_SELECT_TP);
    state_next.transceiver_select_aui_en = (state_next.phase == PH_RUN) && (xsel == TRANSCEIVER_SELECT_AUI);
    state_next.transceiver_select_coax_en = (state_next.phase == PH_RUN) && (xsel == TRANSCEIVER_SELECT_COAX);
    state_next.internal_clk_sel = state_next.strap[CLK_SEL_BIT-STRAP_LSB];
    state_next.mode_normal = (state_next.strap[MODE_LSB-STRAP_LSB +: 2] == MODE_NORMAL);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= full_reset();
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign axi_rsp = state_reg.rsp;
  assign ee_req = state_reg.ee_req;
  assign ee_addr = EE_ADDR_CFG_WORD;
  assign adapter_reset = state_reg.adapter_reset;
  assign slot_visible = state_reg.slot_visible;
  assign irq_drive_en = state_reg.irq_drive_en;
  assign io_hit = state_reg.io_hit;
  assign rom_hit = state_reg.rom_hit;
  assign transceiver_select_tp_en = state_reg.transceiver_select_tp_en;
  assign transceiver_select_aui_en = state_reg.transceiver_select_aui_en;
  assign transceiver_select_coax_en = state_reg.transceiver_select_coax_en;
  assign internal_clk_sel = state_reg.internal_clk_sel;
  assign mode_normal = state_reg.mode_normal;

endmodule // acr_adapter_config_registers

// *** acr_props.sv ***
`timescale 1ns/100ps
module acr_props
  import acr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire acr_pkg::acr_axi_req_t axi_req,
  input wire acr_pkg::acr_axi_rsp_t axi_rsp,
  input wire logic [15:0] host_io_addr,
  input wire logic ee_req,
  input wire logic [5:0] ee_addr,
  input wire logic ee_ack,
  input wire logic adapter_reset,
  input wire logic irq_drive_en,
  input wire logic io_hit,
  input wire logic transceiver_select_tp_en,
  input wire logic transceiver_select_aui_en,
  input wire logic transceiver_select_coax_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // output relations
  // ==========================================
  io_decode_a: assert property (io_hit |-> $past(host_io_addr[15:14]) == 2'b00 &&
    $past(host_io_addr[9:4]) == 6'h20) else $error("io hit without matching address");
  transceiver_select_onehot_a: assert property ($onehot0({transceiver_select_tp_en, transceiver_select_aui_en, transceiver_select_coax_en}))
    else $error("more than one transceiver enabled");
  reset_pulse_a: assert property (adapter_reset |=> !adapter_reset)
    else $error("adapter reset longer than one cycle");
  reset_cause_a: assert property (adapter_reset |-> axi_rsp.bvalid || $past(axi_rsp.bvalid)
    || $past(axi_rsp.bvalid, 2)) else $error("adapter reset without a write");
  irq_off_a: assert property (adapter_reset |-> ##2 !irq_drive_en)
    else $error("irq drivers still on after reset");
  ee_word_a: assert property (ee_req |-> ee_addr == 6'h08)
    else $error("wrong eeprom word");
  ee_drop_a: assert property (ee_req && ee_ack |=> !ee_req)
    else $error("eeprom request held after answer");
  unmapped_a: assert property (axi_req.arvalid && axi_rsp.arready && axi_req.araddr != 8'h10
    && axi_req.araddr != 8'h18 |=> axi_rsp.rvalid && axi_rsp.rresp == 2'b10 && axi_rsp.rdata == 0)
    else $error("unmapped read not refused");
  cfg_zero_a: assert property (axi_req.arvalid && axi_rsp.arready && axi_req.araddr == 8'h10
    |=> axi_rsp.rdata[7:1] == 7'h00 && axi_rsp.rdata[31:16] == 16'h0000)
    else $error("unassigned config bits not zero");
endmodule // acr_props

// *** test_adapter_config_registers.sv ***
`timescale 1ns/100ps
module test_adapter_config_registers;
  import acr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  acr_axi_req_t rq = '0;
  acr_axi_rsp_t rs;
  logic [7:0] strap = 8'h55;
  logic [15:0] io_a = 16'h0000;
  logic [19:0] mem_a = 20'h00000;
  logic ee_ack = 1'b0;
  logic [15:0] ee_data = 16'h0000;
  logic [15:0] ee_word = 16'h0000;
  logic ee_req, a_rst, vis, irq, io_hit, rom_hit, tp, attachment_unit_port, coax, iclk, mnorm;
  logic [5:0] ee_addr;
  logic [17:0] q[$];
  logic [15:0] d;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 93538;
  acr_adapter_config_registers u_dut (.clk(clk), .rst_n(rst_n), .axi_req(rq), .axi_rsp(rs),
    .strap_pins(strap), .host_io_addr(io_a), .host_mem_addr(mem_a), .slot_configured(1'b0),
    .ee_req(ee_req), .ee_addr(ee_addr), .ee_ack(ee_ack), .ee_data(ee_data),
    .adapter_reset(a_rst), .slot_visible(vis), .irq_drive_en(irq), .io_hit(io_hit),
    .rom_hit(rom_hit), .transceiver_select_tp_en(tp), .transceiver_select_aui_en(attachment_unit_port), .transceiver_select_coax_en(coax),
    .internal_clk_sel(iclk), .mode_normal(mnorm));
  always #25 clk = ~clk;
  // ==========================================
  // eeprom reader stand-in and timeout
  // ==========================================
  always @(posedge clk) begin
    ee_ack <= ee_req && !ee_ack;
    ee_data <= ee_word;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // read results are matched in issue order
  always @(posedge clk) begin
    if (rs.rvalid && rq.rready) chk({rs.rresp, rs.rdata[15:0]}, q.pop_front());
  end
  // ==========================================
  // bus tasks
  // ==========================================
  task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] st,
                    input logic [1:0] er);
    @(posedge clk);
    rq.awvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wvalid <= 1'b1;
    rq.wdata <= {16'h0000, v};
    rq.wstrb <= {2'b00, st};
    rq.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (rq.awvalid && rs.awready) rq.awvalid <= 1'b0;
      if (rq.wvalid && rs.wready) rq.wvalid <= 1'b0;
    end while (!rs.bvalid);
    rq.bready <= 1'b0;
    chk(rs.bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
    q.push_back({er, e});
    @(posedge clk);
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    rq.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (rq.arvalid && rs.arready) rq.arvalid <= 1'b0;
    end while (!rs.rvalid);
    rq.rready <= 1'b0;
  endtask
  task automatic wait_load();
    int n;
    n = 0;
    while (!ee_req && n < 12) begin
      @(posedge clk);
      n++;
    end
    while (ee_req) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ==========================================
  // main sequence
  // ==========================================
  initial begin
    ee_word = $random(seed);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wait_load();
    rd(8'h18, ee_word, 2'b00);
    rd(8'h10, 16'hd500, 2'b00);
    #1;
    chk({iclk, mnorm}, 2'b10);
    chk(vis, 1'b1);
    wr(8'h10, 16'hfffb, 2'b11, 2'b00);
    settle();
    chk(irq, 1'b1);
    rd(8'h10, 16'hd501, 2'b00);
    wr(8'h10, 16'h0000, 2'b11, 2'b00);
    settle();
    chk(irq, 1'b0);
    $display("straps and enable done");
    d = $random(seed);
    wr(8'h18, d, 2'b11, 2'b00);
    rd(8'h18, d, 2'b00);
    wr(8'h18, ~d, 2'b01, 2'b00);
    rd(8'h18, {d[15:8], ~d[7:0]}, 2'b00);
    wr(8'h14, 16'hffff, 2'b11, 2'b10);
    rd(8'h14, 16'h0000, 2'b10);
    $display("storage done");
    for (int s = 0; s < 4; s++) begin
      d = {s[1:0], 10'h080, s[1:0] + 2'd1, 2'b01};
      wr(8'h18, d, 2'b11, 2'b00);
      io_a <= {2'b00, d[3:0], 6'h20, 4'h3};
      mem_a <= 20'hd1000;
      settle();
      chk({tp, attachment_unit_port, coax}, {s == 0, s == 1, s == 3});
      chk(io_hit, 1'b1);
      chk(rom_hit, 1'b1);
      io_a <= {2'b01, d[3:0], 6'h20, 4'h3};
      mem_a <= 20'hc1000;
      settle();
      chk(io_hit, 1'b0);
      chk(rom_hit, 1'b0);
    end
    wr(8'h18, 16'h2900, 2'b11, 2'b00);
    mem_a <= 20'hd1000;
    settle();
    chk(rom_hit, 1'b1);
    $display("transceiver and decode done");
    strap <= 8'h4e;
    ee_word = $random(seed);
    wr(8'h10, 16'h0005, 2'b01, 2'b00);
    wait_load();
    rd(8'h10, 16'hce00, 2'b00);
    rd(8'h18, ee_word, 2'b00);
    #1;
    chk({iclk, mnorm}, 2'b01);
    strap <= 8'h3f;
    wr(8'h10, 16'h0004, 2'b01, 2'b00);
    wait_load();
    rd(8'h10, 16'hbf00, 2'b00);
    rd(8'h18, 16'h0000, 2'b00);
    #1;
    chk(irq, 1'b1);
    $display("soft reset done");
    repeat (2) @(posedge clk);
    tally_and_finish();
  end
endmodule // test_adapter_config_registers
bind acr_adapter_config_registers acr_props u_props (.clk(clk), .rst_n(rst_n),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .host_io_addr(host_io_addr), .ee_req(ee_req),
  .ee_addr(ee_addr), .ee_ack(ee_ack), .adapter_reset(adapter_reset),
  .irq_drive_en(irq_drive_en), .io_hit(io_hit), .transceiver_select_tp_en(transceiver_select_tp_en),
  .transceiver_select_aui_en(transceiver_select_aui_en), .transceiver_select_coax_en(transceiver_select_coax_en));
